// ==== iop_calc_datapath.sv ====
// Accumulator, carry, addend, adder and shifter of the I/O processor
`include "iop_calc_map.svh"

// Notes on behaviour
// - Adder sums carry-extended accumulator and addend
// - Non-accumulator add, subtract and shift operands enter through addend register
// - Subtract inverts addend, forces carry-in one
// - Add: one cycle compute, one cycle writeback
// - Adder result can load program address
// - Shift up to 31, circular or end-off
// - Shift takes 17-bit data, 5-bit count
// - Shift one cycle, instruction two cycles
// - Zero count leaves value unchanged
// - End-off count above sixteen clears all
// - Carry is bit sixteen in shifts
// - AND loads accumulator with no extra cycle
// - Accumulator loads from many sources, drives outputs
// - Branches use hidden accumulator, visible one kept
// - Carry captures adder or shifter carry
// - Carry loadable by channel tests, drives jumps
// - Addend loads from aux, stack, operands, memory
// - Operand registers written only from accumulator
module iop_calc_datapath
    import iop_calc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Operation request from instruction control
    input wire logic i_start,
    input wire calc_op_e i_op,
    input wire logic [6:0] i_opcode,
    input wire logic i_circular,
    input wire logic i_to_paddr,
    // Addend load
    input wire logic i_addend_load,
    input wire addend_src_e i_addend_src,
    // Accumulator load and logical product
    input wire acc_src_e i_acc_src,
    input wire logic [`DATA_W-1:0] i_and_operand,
    // Carry load from channel flag tests
    input wire logic i_carry_load,
    input wire logic i_carry_value,
    // Data sources
    input wire logic [`DATA_W-1:0] i_aux_data,
    input wire logic [`DATA_W-1:0] i_field_d,
    input wire logic [`DATA_W-1:0] i_field_k,
    input wire logic [`DATA_W-1:0] i_stack_data,
    input wire logic [`DATA_W-1:0] i_opreg_data,
    input wire logic [`DATA_W-1:0] i_mem_data,
    input wire logic [`DATA_W-1:0] i_chan_data,
    // Accumulator, carry and program address outputs
    output logic [`DATA_W-1:0] o_acc,
    output logic o_carry,
    output logic o_jump_cond,
    output logic o_opreg_we,
    output logic [`DATA_W-1:0] o_paddr,
    output logic o_paddr_load,
    // Status
    output logic o_busy,
    output logic o_done
);
    // ==========================================================
    // State
    typedef struct packed {
        seq_e seq;
        calc_op_e op;
        logic branch;
        logic to_paddr;
        logic [`DATA_W-1:0] acc;
        logic carry;
        logic [`DATA_W-1:0] addend;
        logic [`WIDE_W-1:0] result;
        logic [`DATA_W-1:0] paddr;
        logic paddr_load;
        logic done;
    } calc_state_s;

    calc_state_s state;
    calc_state_s next_state;

    logic [`WIDE_W-1:0] shift_out;
    logic [`WIDE_W-1:0] add_sum;
    logic [`DATA_W-1:0] addend_in;
    logic [`DATA_W-1:0] acc_in;
    logic [`DATA_W-1:0] bg_acc;
    logic is_branch;

    // ==========================================================
    // Shifter
    barrel_shift17 u_shift (
        .i_data({state.carry, state.acc}),
        .i_count(state.addend[`CNT_W-1:0]),
        .i_left(state.op == OP_SHL),
        .i_circular(i_circular),
        .o_result(shift_out)
    );

    // ==========================================================
    // Adder and source selection
    always_comb begin
        is_branch = (i_opcode >= `BR_LO) && (i_opcode <= `BR_HI);
        bg_acc = state.paddr;
        if (state.op == OP_SUB) begin
            add_sum = 17'({state.carry, state.acc} + {1'b0, ~state.addend} + 17'd1);
        end else if (state.branch) begin
            add_sum = 17'({1'b0, bg_acc} + {1'b0, state.addend});
        end else begin
            add_sum = 17'({state.carry, state.acc} + {1'b0, state.addend});
        end
        case (i_addend_src)
            ASRC_AUX: addend_in = i_aux_data;
            ASRC_STACK: addend_in = i_stack_data;
            ASRC_OPREG: addend_in = i_opreg_data;
            ASRC_MEM: addend_in = i_mem_data;
            ASRC_PADDR: addend_in = state.paddr;
            default: addend_in = i_aux_data;
        endcase
        case (i_acc_src)
            LSRC_AUX: acc_in = i_aux_data;
            LSRC_FLD_D: acc_in = i_field_d;
            LSRC_FLD_K: acc_in = i_field_k;
            LSRC_OPREG: acc_in = i_opreg_data;
            LSRC_MEM: acc_in = i_mem_data;
            LSRC_CHAN: acc_in = i_chan_data;
            default: acc_in = i_aux_data;
        endcase
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        next_state.paddr_load = 1'b0;
        next_state.done = 1'b0;
        if (i_addend_load) begin
            next_state.addend = addend_in;
        end
        if (i_carry_load) begin
            next_state.carry = i_carry_value;
        end
        case (state.seq)
            ST_IDLE: begin
                if (i_start) begin
                    case (i_op)
                        OP_ADD, OP_SUB, OP_SHL, OP_SHR: begin
                            next_state.op = i_op;
                            next_state.branch = is_branch && (i_op == OP_ADD);
                            next_state.to_paddr = i_to_paddr || is_branch;
                            next_state.seq = ST_EXEC;
                        end
                        OP_AND: begin
                            next_state.acc = state.acc & i_and_operand;
                            next_state.done = 1'b1;
                        end
                        OP_LOAD: begin
                            next_state.acc = acc_in;
                            next_state.done = 1'b1;
                        end
                        default: begin
                            next_state.seq = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_EXEC: begin
                if ((state.op == OP_SHL) || (state.op == OP_SHR)) begin
                    next_state.result = shift_out;
                end else begin
                    next_state.result = add_sum;
                end
                next_state.seq = ST_WRITE;
            end
            ST_WRITE: begin
                if (state.to_paddr) begin
                    next_state.paddr = state.result[`DATA_W-1:0];
                    next_state.paddr_load = 1'b1;
                end
                if (!state.branch) begin
                    next_state.acc = state.result[`DATA_W-1:0];
                    if (!i_carry_load) begin
                        next_state.carry = state.result[`DATA_W];
                    end
                end
                next_state.done = 1'b1;
                next_state.seq = ST_IDLE;
            end
            default: begin
                next_state.seq = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state.seq <= ST_IDLE;
            state.op <= OP_IDLE;
            state.branch <= 1'b0;
            state.to_paddr <= 1'b0;
            state.acc <= `ACC_RST;
            state.carry <= `CARRY_RST;
            state.addend <= `ADDEND_RST;
            state.result <= '0;
            state.paddr <= `PADDR_RST;
            state.paddr_load <= 1'b0;
            state.done <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Outputs
    assign o_acc = state.acc;
    assign o_carry = state.carry;
    assign o_jump_cond = state.carry;
    assign o_opreg_we = (state.seq == ST_IDLE) && i_start && (i_op == OP_IDLE);
    assign o_paddr = state.paddr;
    assign o_paddr_load = state.paddr_load;
    assign o_busy = (state.seq != ST_IDLE);
    assign o_done = state.done;

    // ==========================================================
    // Checks
    AST_TWO_CP: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state.seq == ST_IDLE && i_start && i_op inside {OP_ADD, OP_SUB, OP_SHL, OP_SHR})
        |=> o_busy ##1 (o_busy && state.seq == ST_WRITE) ##1 (o_done && !o_busy))
        else $error("Arithmetic or shift did not take two cycles");
    AST_AND_NOW: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state.seq == ST_IDLE && i_start && i_op == OP_AND)
        |=> (o_acc == ($past(state.acc) & $past(i_and_operand))) && o_done)
        else $error("Logical product not loaded next cycle");
    AST_BRANCH_KEEP: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state.seq == ST_WRITE && state.branch && !i_carry_load) |=> $stable(o_acc) && $stable(o_carry))
        else $error("Branch altered visible accumulator");
    AST_PADDR: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state.seq == ST_WRITE && state.to_paddr) |=> o_paddr_load && o_paddr == $past(state.result[15:0]))
        else $error("Program address not loaded from adder");
    AST_SUB: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state.seq == ST_EXEC && state.op == OP_SUB)
        |=> state.result == 17'($past({state.carry, state.acc}) + {1'b0, ~$past(state.addend)}
        + 17'd1))
        else $error("Subtract result wrong");
    AST_ADD: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state.seq == ST_EXEC && state.op == OP_ADD && !state.branch)
        |=> state.result == 17'($past({state.carry, state.acc}) + {1'b0, $past(state.addend)}))
        else $error("Add result wrong");
    AST_ZERO_SHIFT: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state.seq == ST_EXEC && state.op inside {OP_SHL, OP_SHR} && state.addend[4:0] == 5'h00)
        |=> state.result == $past({state.carry, state.acc}))
        else $error("Zero count shift changed value");
    AST_ENDOFF: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state.seq == ST_EXEC && state.op inside {OP_SHL, OP_SHR} && !i_circular
        && state.addend[4:0] > 5'h10)
        |=> ##1 (o_acc == 16'h0000 && (o_carry == 1'b0 || $past(i_carry_load))))
        else $error("End-off shift beyond sixteen not cleared");
    AST_CARRY_LOAD: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_carry_load |=> o_carry == $past(i_carry_value))
        else $error("Carry not loaded from channel test");
    AST_ADDEND: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_addend_load && i_addend_src == ASRC_MEM) |=> state.addend == $past(i_mem_data))
        else $error("Addend not loaded from memory");
endmodule

// ==== iop_calc_map.svh ====
// Constants for the adder and shifter datapath
`ifndef IOP_CALC_MAP_SVH
`define IOP_CALC_MAP_SVH

// ==========================================================
// Widths
`define DATA_W 16
`define WIDE_W 17
`define CNT_W 5

// ==========================================================
// Reset values and limits
`define ACC_RST 16'h0000
`define CARRY_RST 1'h0
`define ADDEND_RST 16'h0000
`define PADDR_RST 16'h0000
`define ENDOFF_MAX 5'h10

// ==========================================================
// Branch opcode range, octal 070 to 137
`define BR_LO 7'h38
`define BR_HI 7'h5f

// ==========================================================
// Timing in clock periods
`define ARITH_CP 2

`endif

// ==== iop_calc_pkg.sv ====
// Types for the adder and shifter datapath
package iop_calc_pkg;

    // ==========================================================
    // Operation selector
    typedef enum logic [6:0] {
        OP_IDLE = 7'h01,
        OP_ADD = 7'h02,
        OP_SUB = 7'h04,
        OP_SHL = 7'h08,
        OP_SHR = 7'h10,
        OP_AND = 7'h20,
        OP_LOAD = 7'h40
    } calc_op_e;

    // ==========================================================
    // Addend source
    typedef enum logic [2:0] {
        ASRC_AUX = 3'h0,
        ASRC_STACK = 3'h1,
        ASRC_OPREG = 3'h2,
        ASRC_MEM = 3'h3,
        ASRC_PADDR = 3'h4
    } addend_src_e;

    // ==========================================================
    // Accumulator load source
    typedef enum logic [2:0] {
        LSRC_AUX = 3'h0,
        LSRC_FLD_D = 3'h1,
        LSRC_FLD_K = 3'h2,
        LSRC_OPREG = 3'h3,
        LSRC_MEM = 3'h4,
        LSRC_CHAN = 3'h5
    } acc_src_e;

    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_EXEC = 3'h2,
        ST_WRITE = 3'h4
    } seq_e;

endpackage

// ==== barrel_shift17.sv ====
// Seventeen-bit barrel shifter, circular or end-off with zero fill
`include "iop_calc_map.svh"

module barrel_shift17 (
    // Operand
    input wire logic [`WIDE_W-1:0] i_data,
    input wire logic [`CNT_W-1:0] i_count,
    // Mode
    input wire logic i_left,
    input wire logic i_circular,
    // Result
    output logic [`WIDE_W-1:0] o_result
);
    logic [2*`WIDE_W-1:0] dbl;
    logic [`CNT_W-1:0] mod_cnt;
    logic [`CNT_W:0] rot;

    // ==========================================================
    // Shift network
    always_comb begin
        dbl = {i_data, i_data};
        mod_cnt = (i_count >= 5'd17) ? 5'(i_count - 5'd17) : i_count;
        rot = i_left ? 6'(6'd17 - {1'b0, mod_cnt}) : {1'b0, mod_cnt};
        if (i_count == 5'h00) begin
            o_result = i_data;
        end else if (i_circular) begin
            o_result = 17'(dbl >> rot);
        end else if (i_count > `ENDOFF_MAX) begin
            o_result = '0;
        end else if (i_left) begin
            o_result = 17'(i_data << i_count);
        end else begin
            o_result = i_data >> i_count;
        end
    end
endmodule

// ==== opreg_model.sv ====
// Operand register model standing on the far side of the datapath
module opreg_model (
    // Clock
    input wire logic i_clk,
    // Write from the accumulator
    input wire logic i_we,
    input wire logic [15:0] i_acc,
    // Read data
    output logic [15:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial o_data = 16'h5a5a;

    // ==========================================================
    // Only the accumulator writes the operand register
    always @(posedge i_clk) begin
        if (i_we) begin
            o_data <= i_acc;
        end
    end
endmodule

// ==== tb_io_processor_adder_shifter_datapath.sv ====
// Self-checking bench for the adder and shifter datapath
`include "iop_calc_map.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module tb_io_processor_adder_shifter_datapath
    import iop_calc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_start = 1'b0;
    calc_op_e i_op = OP_IDLE;
    logic [6:0] i_opcode = 7'h00;
    logic i_circular = 1'b0;
    logic i_to_paddr = 1'b0;
    logic i_addend_load = 1'b0;
    addend_src_e i_addend_src = ASRC_AUX;
    acc_src_e i_acc_src = LSRC_AUX;
    logic [`DATA_W-1:0] i_and_operand = 16'h0000;
    logic i_carry_load = 1'b0;
    logic i_carry_value = 1'b0;
    logic [`DATA_W-1:0] i_aux_data = 16'h0000;
    logic [`DATA_W-1:0] i_field_d = 16'h2222;
    logic [`DATA_W-1:0] i_field_k = 16'h3333;
    logic [`DATA_W-1:0] i_stack_data = 16'h0000;
    logic [`DATA_W-1:0] i_mem_data = 16'h4444;
    logic [`DATA_W-1:0] i_chan_data = 16'h5555;
    logic [`DATA_W-1:0] i_opreg_data;
    logic [`DATA_W-1:0] o_acc;
    logic [`DATA_W-1:0] o_paddr;
    logic o_carry;
    logic o_jump_cond;
    logic o_opreg_we;
    logic o_paddr_load;
    logic o_busy;
    logic o_done;
    int fails = 0;
    int total_checks = 0;

    always #12.5 i_clk = ~i_clk;

    iop_calc_datapath dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(i_start), .i_op(i_op),
        .i_opcode(i_opcode), .i_circular(i_circular), .i_to_paddr(i_to_paddr),
        .i_addend_load(i_addend_load), .i_addend_src(i_addend_src), .i_acc_src(i_acc_src),
        .i_and_operand(i_and_operand), .i_carry_load(i_carry_load),
        .i_carry_value(i_carry_value), .i_aux_data(i_aux_data), .i_field_d(i_field_d),
        .i_field_k(i_field_k), .i_stack_data(i_stack_data), .i_opreg_data(i_opreg_data),
        .i_mem_data(i_mem_data), .i_chan_data(i_chan_data), .o_acc(o_acc), .o_carry(o_carry),
        .o_jump_cond(o_jump_cond), .o_opreg_we(o_opreg_we), .o_paddr(o_paddr),
        .o_paddr_load(o_paddr_load), .o_busy(o_busy), .o_done(o_done));

    opreg_model partner (.i_clk(i_clk), .i_we(o_opreg_we), .i_acc(o_acc), .o_data(i_opreg_data));

    // ==========================================================
    // Shared tasks
    task automatic give_verdict();
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic run_op(input calc_op_e op, input int cp);
        int n;
        n = 0;
        @(posedge i_clk);
        i_op <= op;
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
        #1;
        n = 1;
        while (o_done !== 1'b1 && n < 8) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        `CHK("cycles", cp, n)
    endtask

    task automatic set_ac(input logic c, input logic [15:0] a);
        @(posedge i_clk);
        i_aux_data <= a;
        i_acc_src <= LSRC_AUX;
        run_op(OP_LOAD, 1);
        @(posedge i_clk);
        i_carry_load <= 1'b1;
        i_carry_value <= c;
        @(posedge i_clk);
        i_carry_load <= 1'b0;
    endtask

    task automatic calc(input logic c, input logic [15:0] a, input addend_src_e s,
        input logic [15:0] v, input calc_op_e op, input logic circ, input logic [16:0] ex,
        input logic [16:0] m);
        set_ac(c, a);
        @(posedge i_clk);
        i_addend_load <= 1'b1;
        i_addend_src <= s;
        i_aux_data <= v;
        i_stack_data <= v;
        i_mem_data <= v;
        i_circular <= circ;
        @(posedge i_clk);
        i_addend_load <= 1'b0;
        run_op(op, 3);
        `CHK("carry_acc", ex & m, {o_carry, o_acc} & m)
    endtask

    task automatic store_opreg();
        @(posedge i_clk);
        i_op <= OP_IDLE;
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_sources();
        logic [15:0] ex [6];
        ex = '{16'h1111, 16'h2222, 16'h3333, 16'h6666, 16'h4444, 16'h5555};
        set_ac(1'b0, 16'h6666);
        store_opreg();
        @(posedge i_clk);
        i_aux_data <= 16'h1111;
        i_mem_data <= 16'h4444;
        for (int i = 0; i < 6; i++) begin
            @(posedge i_clk);
            i_acc_src <= acc_src_e'(i);
            run_op(OP_LOAD, 1);
            `CHK("acc_load", ex[i], o_acc)
        end
    endtask

    task automatic t_arith();
        calc(1'b0, 16'hffff, ASRC_AUX, 16'h0001, OP_ADD, 1'b0, 17'h10000, 17'h1ffff);
        calc(1'b1, 16'hffff, ASRC_STACK, 16'h0001, OP_ADD, 1'b0, 17'h00000, 17'h1ffff);
        calc(1'b0, 16'h0005, ASRC_MEM, 16'h0007, OP_SUB, 1'b0, 17'h0fffe, 17'h0ffff);
        set_ac(1'b0, 16'habcd);
        store_opreg();
        calc(1'b0, 16'h0003, ASRC_OPREG, 16'h0000, OP_SUB, 1'b0, 17'h05436, 17'h0ffff);
        set_ac(1'b1, 16'hf0f0);
        @(posedge i_clk);
        i_and_operand <= 16'h3cff;
        run_op(OP_AND, 1);
        `CHK("and", 16'h30f0, o_acc)
    endtask

    task automatic t_shift();
        calc(1'b1, 16'ha5a5, ASRC_AUX, 16'hffe0, OP_SHL, 1'b0, 17'h1a5a5, 17'h1ffff);
        calc(1'b1, 16'ha5a5, ASRC_AUX, 16'h0000, OP_SHR, 1'b1, 17'h1a5a5, 17'h1ffff);
        calc(1'b0, 16'h0001, ASRC_AUX, 16'h0010, OP_SHL, 1'b0, 17'h10000, 17'h1ffff);
        calc(1'b1, 16'hffff, ASRC_AUX, 16'h0011, OP_SHR, 1'b0, 17'h00000, 17'h1ffff);
        calc(1'b1, 16'hffff, ASRC_AUX, 16'h001f, OP_SHL, 1'b0, 17'h00000, 17'h1ffff);
        calc(1'b1, 16'h0000, ASRC_AUX, 16'h0001, OP_SHL, 1'b1, 17'h00001, 17'h1ffff);
        calc(1'b0, 16'h0001, ASRC_AUX, 16'h001f, OP_SHR, 1'b1, 17'h00008, 17'h1ffff);
        calc(1'b1, 16'h0000, ASRC_AUX, 16'h0004, OP_SHR, 1'b0, 17'h01000, 17'h1ffff);
    endtask

    task automatic t_branch();
        @(posedge i_clk);
        i_to_paddr <= 1'b1;
        calc(1'b0, 16'h0010, ASRC_AUX, 16'h0100, OP_ADD, 1'b0, 17'h00110, 17'h1ffff);
        `CHK("paddr", 16'h0110, o_paddr)
        `CHK("paddr_load", 1'b1, o_paddr_load)
        i_opcode <= 7'h38;
        calc(1'b0, 16'h0777, ASRC_AUX, 16'h0020, OP_ADD, 1'b0, 17'h00777, 17'h1ffff);
        `CHK("paddr", 16'h0130, o_paddr)
        i_opcode <= 7'h5f;
        calc(1'b1, 16'h0888, ASRC_AUX, 16'h0001, OP_ADD, 1'b0, 17'h10888, 17'h1ffff);
        `CHK("paddr", 16'h0131, o_paddr)
        i_opcode <= 7'h60;
        i_to_paddr <= 1'b0;
        calc(1'b0, 16'h0888, ASRC_AUX, 16'h0001, OP_ADD, 1'b0, 17'h00889, 17'h1ffff);
        `CHK("paddr", 16'h0131, o_paddr)
        `CHK("paddr_load", 1'b0, o_paddr_load)
    endtask

    task automatic t_carry();
        for (int i = 1; i >= 0; i--) begin
            @(posedge i_clk);
            i_carry_load <= 1'b1;
            i_carry_value <= i[0];
            @(posedge i_clk);
            i_carry_load <= 1'b0;
            #1;
            `CHK("carry", i[0], o_carry)
            `CHK("jump_cond", i[0], o_jump_cond)
        end
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge i_clk);
        i_nrst <= 1'b1;
        #1;
        `CHK("reset", 18'h00000, {o_carry, o_busy, o_acc})
        `CHK("reset_paddr", 16'h0000, o_paddr)
        t_sources();
        t_arith();
        t_shift();
        t_branch();
        t_carry();
        give_verdict();
    end

    initial begin
        #(25 * 4000);
        fails++;
        give_verdict();
    end
endmodule
